// file: rtl/tsf_pkg.sv
// constants and types shared by the transmit serial timing block
package tsf_pkg;
  localparam int          POS_W       = 8;
  localparam int          FRM_W       = 5;
  localparam int          CRC_W       = 6;
  localparam int          WORD_W      = 3;
  localparam logic [7:0]  POS_FBIT    = 8'h00;
  localparam logic [7:0]  POS_LAST    = 8'hc0;   // 24 channels x 8 bits after the F bit
  localparam logic [2:0]  LSB_PHASE   = 3'h0;
  localparam logic [4:0]  D4_LAST     = 5'h0b;   // 12 frames per multiframe
  localparam logic [4:0]  ESF_LAST    = 5'h17;   // 24 frames per multiframe
  localparam logic [11:0] D4_FPAT     = 12'h8dc; // frame 1 in the msb
  localparam logic [5:0]  ESF_FPS     = 6'h0b;   // frame 4 in the msb
  localparam logic [5:0]  CRC_POLY    = 6'h03;
  localparam logic [5:0]  CRC_INIT    = 6'h00;
  localparam logic [1:0]  ESF_FPS_SEL = 2'h3;
  localparam logic [1:0]  ESF_CRC_SEL = 2'h1;
  localparam logic        IDLE_BIT    = 1'b1;
  localparam int          W_BIT       = 0;
  localparam int          W_FRM       = 1;
  localparam int          W_MF        = 2;
  typedef enum logic {TSF_SRC_LINE, TSF_SRC_SYS} tsf_src_t;
endpackage

// file: rtl/tsf_pair_buf.sv
// two-entry buffer with valid and ready on both sides
module tsf_pair_buf #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  // fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  logic [W-1:0] mem_reg [2];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;
  logic         push;
  logic         pop;

  assign o_in_ready  = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_NO_OVERFILL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    count_reg == 2'h2 && !pop |=> count_reg == 2'h2)
    else $error("buffer count changed while full without a pop");
endmodule

// file: rtl/tsf_framer_tx.sv
// transmit serial timing: frame counting, overhead insertion, channel clock
// Overview of operation
// RULE1 - frame is one F bit plus 24 eight-bit channels, 125 us
// RULE2 - F bit occupies first bit time, then channels 1 to 24
// RULE3 - channel bits sent msb first, lsb last
// RULE4 - D4 mode counts twelve frames per multiframe
// RULE5 - ESF mode counts twenty-four frames per multiframe
// RULE6 - line side advances on the 1.544 MHz line clock
// RULE7 - store off: serial input sampled on line clock falling edge
// RULE8 - store on: serial input sampled on system clock falling edge
// RULE9 - channel clock high during each channel lsb bit time, else low
// RULE10 - channel clock timed from line or system clock per store enable
// RULE11 - channel clock only active with legacy emulation select high
// RULE12 - transmit and receive elastic stores switch on and off independently
// RULE13 - formatter inserts all frame and multiframe overhead bits
// RULE14 - system clock up to 8.192 MHz or burst is accepted; bits arriving while the two-entry buffer is full are dropped
// RULE15 - store on: system sync pulse marks frame boundary, else ignored
module tsf_framer_tx
  import tsf_pkg::*;
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  // configuration
  input  wire logic i_esf_mode,
  input  wire logic i_tx_es_enable,
  input  wire logic i_rx_es_enable,
  input  wire logic i_legacy_emulation_select,
  // backplane side
  input  wire logic i_transmit_line_clock,
  input  wire logic i_transmit_system_clock,
  input  wire logic i_transmit_system_sync,
  input  wire logic i_ser_data,
  output logic      o_ser_ready,
  // line formatter side
  output logic      o_line_data,
  output logic      o_line_frame,
  output logic      o_line_mframe,
  output logic      o_transmit_channel_clock,
  // store status
  output logic      o_tx_es_active,
  output logic      o_rx_es_active
);
  logic [POS_W-1:0]  pos_reg;
  logic [FRM_W-1:0]  frame_reg;
  logic [CRC_W-1:0]  crc_acc_reg;
  logic [CRC_W-1:0]  crc_hold_reg;
  logic              lclk_d_reg;
  logic              sclk_d_reg;
  logic              chan_clk_reg;
  logic              line_data_reg;
  logic              line_frame_reg;
  logic              line_mframe_reg;
  logic              tx_es_reg;
  logic              rx_es_reg;
  tsf_src_t          src;
  logic              lfall;
  logic              sfall;
  logic              lrise;
  logic              sample;
  logic              sync_hit;
  logic [POS_W-1:0]  cur_pos;
  logic [FRM_W-1:0]  cur_frame;
  logic [POS_W-1:0]  pos_next;
  logic [FRM_W-1:0]  frame_next;
  logic              mf_last;
  logic              fbit;
  logic              word_bit;
  logic [WORD_W-1:0] push_word;
  logic              buf_valid;
  logic [WORD_W-1:0] buf_data;

  function automatic logic [FRM_W-1:0] frame_inc(input logic [FRM_W-1:0] f,
                                                 input logic esf);
    // at or past the last frame wraps, so a mode change mid-multiframe cannot run on
    if (f >= (esf ? ESF_LAST : D4_LAST)) return '0; // RULE4 RULE5
    return f + 5'h01;
  endfunction

  function automatic logic is_lsb(input logic [POS_W-1:0] p);
    return (p != POS_FBIT) && (p[2:0] == LSB_PHASE);
  endfunction

  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic b);
    logic fb;
    fb = c[CRC_W-1] ^ b;
    return {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
  endfunction

  // inputs arrive synchronous to i_sys_clk, so edges come from one delay stage
  assign lfall    = lclk_d_reg && !i_transmit_line_clock;
  assign lrise    = !lclk_d_reg && i_transmit_line_clock;
  assign sfall    = sclk_d_reg && !i_transmit_system_clock;
  assign src      = tx_es_reg ? TSF_SRC_SYS : TSF_SRC_LINE;
  // 250 MHz oversampling resolves even an 8.192 MHz burst clock
  assign sample   = (src == TSF_SRC_SYS) ? sfall : lfall; // RULE7 RULE8 RULE10 RULE14
  assign sync_hit = tx_es_reg && i_transmit_system_sync; // RULE15
  assign cur_pos  = sync_hit ? POS_FBIT : pos_reg;
  assign cur_frame = (sync_hit && pos_reg != POS_FBIT) ? frame_inc(frame_reg, i_esf_mode)
                                                        : frame_reg;
  assign pos_next   = (cur_pos == POS_LAST) ? POS_FBIT : cur_pos + 8'h01; // RULE1 RULE2
  assign frame_next = (cur_pos == POS_LAST) ? frame_inc(cur_frame, i_esf_mode) : cur_frame;
  assign mf_last    = (cur_frame == (i_esf_mode ? ESF_LAST : D4_LAST));

  // overhead bit for the current frame
  always_comb begin
    fbit = IDLE_BIT;
    if (!i_esf_mode) begin
      fbit = D4_FPAT[D4_LAST[3:0] - cur_frame[3:0]];
    end else if (cur_frame[1:0] == ESF_FPS_SEL) begin
      fbit = ESF_FPS[3'h5 - cur_frame[4:2]];
    end else if (cur_frame[1:0] == ESF_CRC_SEL) begin
      fbit = crc_hold_reg[3'h5 - cur_frame[4:2]];
    end
  end

  // payload passes in arrival order, so bit 1 (msb) of each channel leads
  assign word_bit  = (cur_pos == POS_FBIT) ? fbit : i_ser_data; // RULE3 RULE13
  assign push_word = {(cur_pos == POS_FBIT) && (cur_frame == '0),
                      cur_pos == POS_FBIT, word_bit};

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lclk_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end else begin
      lclk_d_reg <= i_transmit_line_clock;
      sclk_d_reg <= i_transmit_system_clock;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_es_reg <= 1'b0;
      rx_es_reg <= 1'b0;
    end else begin
      tx_es_reg <= i_tx_es_enable; // RULE12
      rx_es_reg <= i_rx_es_enable; // RULE12
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_reg   <= POS_FBIT;
      frame_reg <= '0;
    end else if (sample) begin
      pos_reg   <= pos_next;
      frame_reg <= frame_next;
    end
  end

  // crc over a whole multiframe with F bits counted as ones, sent next multiframe
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      crc_acc_reg  <= CRC_INIT;
      crc_hold_reg <= CRC_INIT;
    end else if (sample) begin
      if (cur_pos == POS_LAST && mf_last) begin
        crc_acc_reg  <= CRC_INIT;
        crc_hold_reg <= crc_step(crc_acc_reg, i_ser_data); // RULE13
      end else begin
        crc_acc_reg <= crc_step(crc_acc_reg, (cur_pos == POS_FBIT) ? IDLE_BIT : i_ser_data);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      chan_clk_reg <= 1'b0;
    end else begin
      chan_clk_reg <= i_legacy_emulation_select &&
                      is_lsb(sample ? pos_next : pos_reg); // RULE9 RULE11
    end
  end

  // a full buffer drops the bit; o_ser_ready tells the source
  tsf_pair_buf #(.W(WORD_W)) u_buf (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (sample),
    .i_in_data   (push_word),
    .o_in_ready  (o_ser_ready),
    .o_out_valid (buf_valid),
    .o_out_data  (buf_data),
    .i_out_ready (lrise)
  );

  // line side takes one word per line clock rising edge; underrun sends idle ones
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_data_reg   <= IDLE_BIT;
      line_frame_reg  <= 1'b0;
      line_mframe_reg <= 1'b0;
    end else if (lrise) begin
      line_data_reg   <= buf_valid ? buf_data[W_BIT] : IDLE_BIT; // RULE6
      line_frame_reg  <= buf_valid && buf_data[W_FRM];
      line_mframe_reg <= buf_valid && buf_data[W_MF];
    end
  end

  assign o_line_data              = line_data_reg;
  assign o_line_frame             = line_frame_reg;
  assign o_line_mframe            = line_mframe_reg;
  assign o_transmit_channel_clock = chan_clk_reg;
  assign o_tx_es_active           = tx_es_reg;
  assign o_rx_es_active           = rx_es_reg;

  AST_POS_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE1
    sample && cur_pos == POS_LAST |=> pos_reg == POS_FBIT)
    else $error("frame did not wrap after bit 193");
  AST_FBIT_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE2
    sample && cur_pos == POS_FBIT |-> push_word[W_FRM] && word_bit == fbit)
    else $error("F bit not in first bit time");
  AST_MSB_ORDER: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE3
    sample && cur_pos != POS_FBIT |-> word_bit == i_ser_data && !push_word[W_FRM])
    else $error("channel bit not passed in order");
  AST_D4_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE4
    sample && !i_esf_mode && cur_pos == POS_LAST && cur_frame == D4_LAST |=> frame_reg == '0)
    else $error("D4 multiframe not twelve frames");
  AST_ESF_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE5
    sample && i_esf_mode && cur_pos == POS_LAST && cur_frame == ESF_LAST |=> frame_reg == '0)
    else $error("ESF multiframe not twenty-four frames");
  AST_LINE_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE6
    lrise && buf_valid |=> o_line_data == $past(buf_data[W_BIT]))
    else $error("line bit not taken on line clock rise");
  AST_LINE_SAMPLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE7
    !tx_es_reg && $past(i_transmit_line_clock) && !i_transmit_line_clock |-> sample)
    else $error("line clock fall not sampled");
  AST_SYS_SAMPLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE8
    tx_es_reg && $past(i_transmit_system_clock) && !i_transmit_system_clock |-> sample)
    else $error("system clock fall not sampled");
  AST_CHAN_LSB: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE9
    o_transmit_channel_clock |-> is_lsb(pos_reg))
    else $error("channel clock high outside lsb");
  AST_CHAN_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE11
    !$past(i_legacy_emulation_select) |-> !o_transmit_channel_clock)
    else $error("channel clock active without legacy select");
  AST_SYNC_BOUND: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE15
    sample && tx_es_reg && i_transmit_system_sync |=> pos_reg == 8'h01)
    else $error("system sync did not set frame boundary");
endmodule

// file: verif/tsf_bp.sv
// backplane model: line and system clocks, serial data and sync
module tsf_bp (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  // control from bench
  input  wire logic       i_sel_sys,
  input  wire logic       i_sys_run,
  input  wire logic       i_fast,
  input  wire logic       i_sync_arm,
  // toward block
  output logic            o_line_clk,
  output logic            o_sys_clk,
  output logic            o_data,
  output logic            o_sync,
  // bench status
  output logic            o_fall,
  output logic            o_lrise,
  output logic [7:0]      o_idx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] lc  = 3'h0;
  logic [2:0] sc  = 3'h0;
  logic [7:0] nxt = 8'h00;
  logic [2:0] h;
  logic [7:0] cur;
  logic [7:0] ch;
  logic       rise;
  logic       fall;
  // burst rate is faster than the line
  assign h    = i_fast ? 3'h2 : 3'h3;
  assign rise = i_sel_sys ? (i_sys_run && sc == 3'h0) : (lc == 3'h0);
  assign fall = i_sel_sys ? (i_sys_run && sc == h) : (lc == 3'h3);
  // sync restarts the count only where the store is on
  assign cur  = (i_sync_arm && i_sel_sys && nxt == 8'h64) ? 8'h00 : nxt;
  assign ch   = (cur - 8'h01) / 8'h08 + 8'h01;
  always @(posedge i_sys_clk) begin
    lc <= (lc == 3'h5) ? 3'h0 : lc + 3'h1;
    sc <= (!i_sys_run || sc == 2 * h - 1) ? 3'h0 : sc + 3'h1;
    o_line_clk <= lc < 3'h3;
    o_sys_clk <= i_sys_run && sc < h;
    o_lrise <= lc == 3'h0;
    o_fall <= fall;
    if (!i_reset_n) begin
      nxt <= 8'h00;
      o_idx <= 8'h00;
      o_data <= 1'b1;
      o_sync <= 1'b0;
    end else if (rise) begin
      o_idx <= cur;
      o_data <= (cur == 8'h00) || ch[3'h7 - 3'((cur - 8'h01) % 8'h08)];
      o_sync <= i_sync_arm && nxt == 8'h64;
    end else if (fall) begin
      nxt <= (o_idx == 8'hc0) ? 8'h00 : o_idx + 8'h01;
    end
  end
endmodule

// file: verif/tb_t1_transmit_serial_timing.sv
// testbench for the transmit serial timing block
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_t1_transmit_serial_timing
  import tsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, esf = 1'b0, tx_es = 1'b0, rx_es = 1'b0;
  logic leg = 1'b1, run = 1'b0, fast = 1'b0, arm = 1'b0;
  logic mon_en = 1'b0, tcc_chk = 1'b0, len_chk = 1'b1;
  logic ser_rdy, ldat, lfr, lmf, tcc, txa, rxa, lclk, sclk, sdat, ssync, bfall, blrise;
  logic [7:0] bidx;
  logic [2:0] fd = 3'h0, lr = 3'h0;
  logic [5:0] crc_a = 6'h00, crc_h = 6'h00;
  int n_errors = 0, samples_checked = 0, bcnt = 0, fidx = 0, nfr = 0, started = 0;
  always #2 clk = ~clk;
  tsf_framer_tx i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_esf_mode(esf),
    .i_tx_es_enable(tx_es), .i_rx_es_enable(rx_es), .i_legacy_emulation_select(leg),
    .i_transmit_line_clock(lclk), .i_transmit_system_clock(sclk),
    .i_transmit_system_sync(ssync), .i_ser_data(sdat), .o_ser_ready(ser_rdy),
    .o_line_data(ldat), .o_line_frame(lfr), .o_line_mframe(lmf),
    .o_transmit_channel_clock(tcc), .o_tx_es_active(txa), .o_rx_es_active(rxa));
  tsf_bp i_bp (.i_sys_clk(clk), .i_reset_n(rst_n), .i_sel_sys(tx_es), .i_sys_run(run),
    .i_fast(fast), .i_sync_arm(arm), .o_line_clk(lclk), .o_sys_clk(sclk), .o_data(sdat),
    .o_sync(ssync), .o_fall(bfall), .o_lrise(blrise), .o_idx(bidx));
  function automatic logic fexp(int f);
    if (!esf) return D4_FPAT[11 - f];
    if (f % 4 == 3) return ESF_FPS[5 - f / 4];
    return 1'b1;
  endfunction
  function automatic logic pexp(int p);
    logic [7:0] c;
    c = 8'((p - 1) / 8 + 1);
    return c[7 - (p - 1) % 8];
  endfunction
  function automatic logic [5:0] cstep(logic [5:0] c, logic b);
    return {c[4:0], 1'b0} ^ ((c[5] ^ b) ? CRC_POLY : 6'h00);
  endfunction
  // outputs are read three edges after the event, once settled
  always @(posedge clk) begin
    fd <= {fd[1:0], bfall};
    lr <= {lr[1:0], blrise};
    if (tcc_chk && fd[1]) `CHK("chan clk", leg & (bidx[2:0] == 3'h7), tcc)
    if (mon_en && lr[1] && lfr === 1'b1) begin
      if (started && len_chk) `CHK("frame len", 193, bcnt)
      if (started && lmf === 1'b1) `CHK("mf len", esf ? 23 : 11, fidx)
      fidx = (lmf === 1'b1) ? 0 : fidx + 1;
      // crc of the previous multiframe, F bits counted as ones
      if (lmf === 1'b1) begin
        crc_h = started ? crc_a : CRC_INIT;
        crc_a = CRC_INIT;
      end
      crc_a = cstep(crc_a, 1'b1);
      if (esf && fidx % 4 == 1) `CHK("crc bit", crc_h[5 - fidx / 4], ldat)
      else `CHK("f bit", fexp(fidx), ldat)
      started = 1;
      bcnt = 1;
      nfr++;
    end else if (mon_en && lr[1] && started) begin
      `CHK("data", pexp(bcnt), ldat)
      crc_a = cstep(crc_a, pexp(bcnt));
      bcnt++;
    end
  end
  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a bound that runs out counts as a mismatch and ends the run
  task automatic tmo(logic ok);
    if (!ok) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic wait_fr(int n);
    int t;
    t = nfr + n;
    for (int k = 0; k < 1300 * n && nfr < t; k++) @(negedge clk);
    tmo(nfr >= t);
  endtask
  // release just after a line rise so the first fall is seen
  task automatic do_reset(logic e, logic s);
    @(posedge clk) rst_n <= 1'b0;
    {esf, tx_es, rx_es, run, mon_en, tcc_chk, fast, leg} <= {e, s, !s, 5'h01};
    repeat (12) @(posedge clk);
    started = 0;
    fidx = 0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      if (blrise) break;
    end
    tmo(blrise);
    @(posedge clk) rst_n <= 1'b1;
    {mon_en, tcc_chk} <= 2'h3;
  endtask
  task automatic s_d4_line();
    do_reset(1'b0, 1'b0);
    wait_fr(2);
    @(posedge clk) arm <= 1'b1;
    wait_fr(1);
    @(posedge clk) arm <= 1'b0;
    wait_fr(12);
    `CHK("tx store", 1'b0, txa)
    `CHK("rx store", 1'b1, rxa)
  endtask
  task automatic s_esf_sys();
    do_reset(1'b1, 1'b1);
    @(posedge clk) run <= 1'b1;
    wait_fr(3);
    @(posedge clk) arm <= 1'b1;
    for (int k = 0; k < 1300; k++) begin
      @(negedge clk);
      if (ssync) break;
    end
    tmo(ssync);
    @(posedge clk) {arm, len_chk} <= 2'h0;
    wait_fr(2);
    @(posedge clk) len_chk <= 1'b1;
    wait_fr(8);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      if (bfall) break;
    end
    tmo(bfall);
    @(posedge clk) leg <= 1'b0;
    wait_fr(12);
    `CHK("tx store", 1'b1, txa)
    `CHK("rx store", 1'b0, rxa)
  endtask
  // burst overruns the buffer, then a stop drains it to idle
  task automatic s_burst();
    @(posedge clk) {mon_en, tcc_chk, fast} <= 3'h1;
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      if (ser_rdy === 1'b0) break;
    end
    `CHK("ready low", 1'b0, ser_rdy)
    @(posedge clk) run <= 1'b0;
    repeat (40) @(negedge clk);
    `CHK("ready high", 1'b1, ser_rdy)
    `CHK("idle data", 1'b1, ldat)
    `CHK("idle frame", 1'b0, lfr)
  endtask
  initial begin
    s_d4_line();
    s_esf_sys();
    s_burst();
    end_of_test();
  end
endmodule
